// ===== hw/sftx_crc4.sv
// four-bit frame checksum over three data nibbles
// assumes the caller holds the data steady for the whole frame
`timescale 1ns/1ps
module sftx_crc4 (
  // data nibbles, first sent nibble in the top bits
  input  wire logic [11:0] data_nib,
  // checksum nibble
  output logic      [3:0]  crc_nib
);

  function automatic logic [3:0] crc_calc(input logic [11:0] d);
    logic [15:0] msg;
    logic [3:0]  c;
    logic        fb;
    msg = {d, 4'h0};
    c   = sftx_pkg::CRC_SEED;
    for (int i = 15; i >= 0; i--)
    begin
      fb = c[3];
      c  = {c[2:0], msg[i]};
      if (fb)
      begin
        c = c ^ sftx_pkg::CRC_POLY;
      end
    end
    return c;
  endfunction : crc_calc

  // augmented division, seed then trailing zero nibble
  assign crc_nib = crc_calc(data_nib); // [RL16]

endmodule : sftx_crc4

// ===== hw/sftx_pkg.sv
// shared constants and types of the single-edge nibble frame transmitter
// assumes a 20 MHz reference clock and a 32-bit register port
package sftx_pkg;

  // clock and tick timing
  localparam int          CLK_HZ       = 20_000_000;
  localparam int          TICK_TIME_NS = 3000;
  localparam logic [7:0]  TICK_DIV_RST = 8'((TICK_TIME_NS * (CLK_HZ / 1_000_000)) / 1000 - 1);

  // nibble and frame lengths in ticks
  localparam logic [11:0] LOW_TICKS    = 12'h005;
  localparam logic [11:0] HIGH_BASE    = 12'h007;
  localparam logic [11:0] SYNC_TICKS   = 12'h038;
  localparam logic [11:0] PAUSE_MIN    = 12'h00c;
  localparam logic [11:0] PAUSE_RST    = 12'h0c8;
  localparam logic [11:0] FULL_SCALE   = 12'hfff;

  // checksum
  localparam logic [3:0]  CRC_SEED     = 4'h5;
  localparam logic [3:0]  CRC_POLY     = 4'hd;

  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_TICK    = 8'h04;
  localparam logic [7:0]  ADDR_DRIVE   = 8'h08;
  localparam logic [7:0]  ADDR_PAUSE   = 8'h0c;
  localparam logic [7:0]  ADDR_UNIT    = 8'h10;
  localparam logic [7:0]  ADDR_SERIAL  = 8'h14;
  localparam logic [7:0]  ADDR_STATUS  = 8'h18;

  // control and unit field positions
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_MODE_LSB   = 1;
  localparam int          CTRL_PAUSE_BIT  = 3;
  localparam int          CTRL_SERIAL_BIT = 4;
  localparam int          UNIT_ADDR_LSB   = 0;
  localparam int          UNIT_CNT_LSB    = 2;

  // reset values
  localparam logic [4:0]  CTRL_RST     = 5'h01;
  localparam logic [1:0]  DRIVE_RST    = 2'h1;
  localparam logic [3:0]  UNIT_RST     = 4'h0;
  localparam logic [15:0] SERIAL_RST   = 16'h0000;

  // frame segments
  localparam logic [2:0]  SEG_SYNC     = 3'h0;
  localparam logic [2:0]  SEG_STAT     = 3'h1;
  localparam logic [2:0]  SEG_D0       = 3'h2;
  localparam logic [2:0]  SEG_D1       = 3'h3;
  localparam logic [2:0]  SEG_D2       = 3'h4;
  localparam logic [2:0]  SEG_CRC      = 3'h5;
  localparam logic [2:0]  SEG_PAUSE    = 3'h6;

  typedef enum logic [1:0] {
    MODE_FREE = 2'h0,
    MODE_TRIG = 2'h1,
    MODE_ADDR = 2'h2,
    MODE_POLL = 2'h3
  } sftx_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LOW  = 3'h2,
    ST_HIGH = 3'h4
  } sftx_state_t;

endpackage : sftx_pkg

// ===== hw/sftx_top.sv
// single-edge nibble frame transmitter with register port
// assumes synchronous inputs, open-drain line pulled up outside
// Summary of operation
// [RL1] angle sent as unsigned 12-bit full-scale code
// [RL2] frame options come from loaded configuration registers
// [RL3] free-streaming mode sends frames without request
// [RL4] triggered mode sends only on receiver request
// [RL5] shared line: only addressed or polled unit sends
// [RL6] nibble is low interval then high interval
// [RL7] low interval always five ticks
// [RL8] high interval seven ticks plus nibble value
// [RL9] tick period programmable, intervals counted in ticks
// [RL10] falling edge drive strength is programmable
// [RL11] sync, status, data, crc, optional pause order
// [RL12] status nibble carries status and serial bits
// [RL13] data nibbles carry angle, crc follows
// [RL14] optional pause pulse after crc nibble
// [RL15] programming mode aborts frame at once
// [RL16] sync 56 ticks, standard four-bit checksum
// [RL17] receiver derives tick from sync length
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
module sftx_top (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [31:0] reg_rdata,
  // measurement and status
  input  wire logic [15:0] angle_in,
  input  wire logic [3:0]  status_in,
  input  wire logic        prog_mode,
  // frame requests
  input  wire logic        trig_req,
  input  wire logic        addr_req,
  input  wire logic [1:0]  addr_sel,
  input  wire logic        poll_req,
  // line
  output logic             sent_out,
  output logic             sent_oe,
  output logic      [1:0]  sent_drive,
  // frame status
  output logic             frame_busy,
  output logic             frame_done
);

  sftx_pkg::sftx_state_t state_reg;
  sftx_pkg::sftx_mode_t  mode;
  logic [4:0]  ctrl_reg;
  logic [7:0]  tick_div_reg;
  logic [1:0]  drive_reg;
  logic [11:0] pause_reg;
  logic [3:0]  unit_reg;
  logic [15:0] serial_reg;
  logic [31:0] rdata_reg;
  logic [7:0]  div_lat_reg;
  logic [7:0]  presc_reg;
  logic        tick;
  logic [2:0]  seg_reg;
  logic [11:0] tcnt_reg;
  logic [11:0] high_len;
  logic        oe_reg;
  logic        done_reg;
  logic        pause_lat_reg;
  logic        req_pend_reg;
  logic        req_set;
  logic [1:0]  poll_cnt_reg;
  logic [11:0] angle_hold_reg;
  logic [11:0] angle_code;
  logic [3:0]  stat_nib_reg;
  logic [3:0]  stat_nib_next;
  logic [11:0] data_nib_reg;
  logic [3:0]  crc_nib;
  logic [3:0]  ser_idx_reg;
  logic [15:0] frame_cnt_reg;
  logic        start;
  logic        seg_end;
  logic        last_seg;
  logic        tx_en;
  logic        pause_en;
  logic        serial_en;
  logic [1:0]  unit_addr;
  logic [1:0]  unit_cnt;

  function automatic logic [3:0] nib_of(input logic [2:0] seg, input logic [3:0] st,
                                        input logic [11:0] dat, input logic [3:0] crc);
    logic [3:0] n;
    n = 4'h0;
    unique case (seg)
      sftx_pkg::SEG_STAT: n = st;
      sftx_pkg::SEG_D0:   n = dat[11:8];
      sftx_pkg::SEG_D1:   n = dat[7:4];
      sftx_pkg::SEG_D2:   n = dat[3:0];
      sftx_pkg::SEG_CRC:  n = crc;
      default:            n = 4'h0;
    endcase
    return n;
  endfunction : nib_of

  function automatic logic [11:0] high_ticks(input logic [2:0] seg, input logic [3:0] nib,
                                             input logic [11:0] pause);
    logic [11:0] h;
    if (seg == sftx_pkg::SEG_SYNC)
    begin
      h = sftx_pkg::SYNC_TICKS - sftx_pkg::LOW_TICKS; // [RL16] [RL17]
    end
    else if (seg == sftx_pkg::SEG_PAUSE)
    begin
      h = (pause < sftx_pkg::PAUSE_MIN) ? sftx_pkg::HIGH_BASE : pause - sftx_pkg::LOW_TICKS;
    end
    else
    begin
      h = sftx_pkg::HIGH_BASE + {8'h00, nib};
    end
    return h;
  endfunction : high_ticks

  assign tx_en      = ctrl_reg[sftx_pkg::CTRL_EN_BIT];
  assign mode       = sftx_pkg::sftx_mode_t'(ctrl_reg[sftx_pkg::CTRL_MODE_LSB +: 2]);
  assign pause_en   = ctrl_reg[sftx_pkg::CTRL_PAUSE_BIT];
  assign serial_en  = ctrl_reg[sftx_pkg::CTRL_SERIAL_BIT];
  assign unit_addr  = unit_reg[sftx_pkg::UNIT_ADDR_LSB +: 2];
  assign unit_cnt   = unit_reg[sftx_pkg::UNIT_CNT_LSB +: 2];

  // configuration registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg     <= sftx_pkg::CTRL_RST;
      tick_div_reg <= sftx_pkg::TICK_DIV_RST;
      drive_reg    <= sftx_pkg::DRIVE_RST;
      pause_reg    <= sftx_pkg::PAUSE_RST;
      unit_reg     <= sftx_pkg::UNIT_RST;
      serial_reg   <= sftx_pkg::SERIAL_RST;
    end
    else if (ce && reg_we)
    begin
      unique case (reg_addr)
        sftx_pkg::ADDR_CTRL:   ctrl_reg     <= reg_wdata[4:0]; // [RL2]
        sftx_pkg::ADDR_TICK:   tick_div_reg <= reg_wdata[7:0]; // [RL9]
        sftx_pkg::ADDR_DRIVE:  drive_reg    <= reg_wdata[1:0]; // [RL10]
        sftx_pkg::ADDR_PAUSE:  pause_reg    <= reg_wdata[11:0];
        sftx_pkg::ADDR_UNIT:   unit_reg     <= reg_wdata[3:0];
        sftx_pkg::ADDR_SERIAL: serial_reg   <= reg_wdata[15:0];
        default:               ;
      endcase
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      rdata_reg <= 32'h0000_0000;
      if (reg_re)
      begin
        unique case (reg_addr)
          sftx_pkg::ADDR_CTRL:   rdata_reg <= {27'h0, ctrl_reg};
          sftx_pkg::ADDR_TICK:   rdata_reg <= {24'h0, tick_div_reg};
          sftx_pkg::ADDR_DRIVE:  rdata_reg <= {30'h0, drive_reg};
          sftx_pkg::ADDR_PAUSE:  rdata_reg <= {20'h0, pause_reg};
          sftx_pkg::ADDR_UNIT:   rdata_reg <= {28'h0, unit_reg};
          sftx_pkg::ADDR_SERIAL: rdata_reg <= {16'h0, serial_reg};
          sftx_pkg::ADDR_STATUS: rdata_reg <= {frame_cnt_reg, angle_hold_reg, 2'h0, prog_mode, frame_busy};
          default:               rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata  = rdata_reg;
  assign sent_drive = drive_reg; // [RL10]

  // frame request qualification
  assign req_set = (mode == sftx_pkg::MODE_TRIG && trig_req) || // [RL4]
                   (mode == sftx_pkg::MODE_ADDR && addr_req && addr_sel == unit_addr) || // [RL5]
                   (mode == sftx_pkg::MODE_POLL && poll_req && poll_cnt_reg == unit_addr); // [RL5]

  assign start = ce && state_reg == sftx_pkg::ST_IDLE && tx_en && !prog_mode &&
                 (mode == sftx_pkg::MODE_FREE || req_pend_reg); // [RL3] [RL4]

  // pending request, a new request beats the clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_pend_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (req_set)
      begin
        req_pend_reg <= 1'b1;
      end
      else if (start || mode == sftx_pkg::MODE_FREE)
      begin
        req_pend_reg <= 1'b0;
      end
    end
  end

  // poll sequence position
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      poll_cnt_reg <= 2'h0;
    end
    else if (ce && poll_req && mode == sftx_pkg::MODE_POLL)
    begin
      poll_cnt_reg <= (poll_cnt_reg == unit_cnt) ? 2'h0 : poll_cnt_reg + 2'h1; // [RL5]
    end
  end

  // angle sampling: at request when requested, else at frame start
  assign angle_code = angle_in[15:4]; // [RL1]

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      angle_hold_reg <= 12'h000;
    end
    else if (ce && (req_set || (start && mode == sftx_pkg::MODE_FREE)))
    begin
      angle_hold_reg <= angle_code; // [RL1] [RL4]
    end
  end

  // status nibble with optional serial message bit
  always_comb
  begin
    stat_nib_next = status_in;
    if (serial_en)
    begin
      stat_nib_next = {serial_reg[4'hf - ser_idx_reg], ser_idx_reg == 4'h0, status_in[1:0]}; // [RL12]
    end
  end

  // frame contents latched at start
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_nib_reg  <= 4'h0;
      data_nib_reg  <= 12'h000;
      div_lat_reg   <= sftx_pkg::TICK_DIV_RST;
      pause_lat_reg <= 1'b0;
    end
    else if (start)
    begin
      stat_nib_reg  <= stat_nib_next; // [RL12]
      data_nib_reg  <= (mode == sftx_pkg::MODE_FREE) ? angle_code : angle_hold_reg; // [RL13]
      div_lat_reg   <= tick_div_reg; // [RL9]
      pause_lat_reg <= pause_en; // [RL14]
    end
  end

  sftx_crc4 u_crc (
    .data_nib (data_nib_reg),
    .crc_nib  (crc_nib)
  ); // [RL13]

  // tick prescaler, realigned at each frame start
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_reg <= 8'h00;
    end
    else if (ce)
    begin
      if (start || prog_mode || state_reg == sftx_pkg::ST_IDLE)
      begin
        presc_reg <= 8'h00;
      end
      else
      begin
        presc_reg <= (presc_reg == div_lat_reg) ? 8'h00 : presc_reg + 8'h01; // [RL9]
      end
    end
  end

  assign tick     = ce && state_reg != sftx_pkg::ST_IDLE && presc_reg == div_lat_reg;
  assign high_len = high_ticks(seg_reg, nib_of(seg_reg, stat_nib_reg, data_nib_reg, crc_nib), pause_reg);
  assign seg_end  = tick && state_reg == sftx_pkg::ST_HIGH && tcnt_reg == high_len - 12'h001;
  assign last_seg = seg_reg == sftx_pkg::SEG_PAUSE || (seg_reg == sftx_pkg::SEG_CRC && !pause_lat_reg);

  // nibble sequencer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= sftx_pkg::ST_IDLE;
      seg_reg   <= sftx_pkg::SEG_SYNC;
      tcnt_reg  <= 12'h000;
      oe_reg    <= 1'b0;
      done_reg  <= 1'b0;
    end
    else if (ce)
    begin
      done_reg <= 1'b0;
      if (prog_mode)
      begin
        state_reg <= sftx_pkg::ST_IDLE; // [RL15]
        seg_reg   <= sftx_pkg::SEG_SYNC;
        tcnt_reg  <= 12'h000;
        oe_reg    <= 1'b0; // [RL15]
      end
      else
      begin
        unique case (state_reg)
          sftx_pkg::ST_IDLE:
          begin
            if (start)
            begin
              state_reg <= sftx_pkg::ST_LOW; // [RL11]
              seg_reg   <= sftx_pkg::SEG_SYNC;
              tcnt_reg  <= 12'h000;
              oe_reg    <= 1'b1;
            end
          end
          sftx_pkg::ST_LOW:
          begin
            if (tick)
            begin
              if (tcnt_reg == sftx_pkg::LOW_TICKS - 12'h001)
              begin
                state_reg <= sftx_pkg::ST_HIGH; // [RL6] [RL7]
                tcnt_reg  <= 12'h000;
                oe_reg    <= 1'b0;
              end
              else
              begin
                tcnt_reg <= tcnt_reg + 12'h001;
              end
            end
          end
          sftx_pkg::ST_HIGH:
          begin
            if (seg_end)
            begin
              tcnt_reg <= 12'h000; // [RL8] [RL16]
              if (last_seg)
              begin
                state_reg <= sftx_pkg::ST_IDLE; // [RL14]
                seg_reg   <= sftx_pkg::SEG_SYNC;
                done_reg  <= 1'b1;
              end
              else
              begin
                state_reg <= sftx_pkg::ST_LOW; // [RL6] [RL11]
                seg_reg   <= seg_reg + 3'h1;
                oe_reg    <= 1'b1;
              end
            end
            else if (tick)
            begin
              tcnt_reg <= tcnt_reg + 12'h001;
            end
          end
        endcase
      end
    end
  end

  // serial message position and frame count
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ser_idx_reg   <= 4'h0;
      frame_cnt_reg <= 16'h0000;
    end
    else if (ce && seg_end && last_seg && !prog_mode)
    begin
      frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      ser_idx_reg   <= serial_en ? ser_idx_reg + 4'h1 : 4'h0; // [RL12]
    end
  end

  // open-drain line: drive low only
  assign sent_out   = 1'b0;
  assign sent_oe    = oe_reg; // [RL6]
  assign frame_busy = state_reg != sftx_pkg::ST_IDLE;
  assign frame_done = done_reg;

  // helper: ce cycles spent low in the current interval
  logic [15:0] low_cyc;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_cyc <= 16'h0000;
    end
    else if (!oe_reg)
    begin
      low_cyc <= 16'h0000;
    end
    else if (ce)
    begin
      low_cyc <= low_cyc + 16'h0001;
    end
  end

  sequence s_frame_start;
    start ##1 (state_reg == sftx_pkg::ST_LOW && seg_reg == sftx_pkg::SEG_SYNC);
  endsequence

  sequence s_crc_end;
    seg_end && seg_reg == sftx_pkg::SEG_CRC && !prog_mode;
  endsequence

  AST_LOW_FIVE_TICKS: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL7]
    $fell(oe_reg) && !$past(prog_mode) |-> low_cyc == 16'(sftx_pkg::LOW_TICKS) * ({8'h00, div_lat_reg} + 16'h0001))
    else $error("low interval not five ticks");

  AST_PROG_ABORT: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL15]
    ce && prog_mode |=> state_reg == sftx_pkg::ST_IDLE && !sent_oe)
    else $error("frame not abandoned in programming mode");

  AST_SYNC_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL16]
    seg_reg == sftx_pkg::SEG_SYNC && state_reg == sftx_pkg::ST_HIGH |-> high_len == 12'h033)
    else $error("sync pulse not 56 ticks");

  AST_NIBBLE_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL8]
    seg_reg == sftx_pkg::SEG_D0 |-> high_len == 12'h007 + {8'h00, data_nib_reg[11:8]} && high_len <= 12'h016)
    else $error("data nibble high interval wrong");

  AST_SEG_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL11]
    $changed(seg_reg) |-> seg_reg == $past(seg_reg) + 3'h1 || seg_reg == sftx_pkg::SEG_SYNC)
    else $error("frame segments out of order");

  AST_FRAME_START: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL11]
    s_frame_start |-> sent_oe && tcnt_reg == 12'h000 && presc_reg == 8'h00)
    else $error("frame did not open with sync low");

  AST_PAUSE_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL14]
    s_crc_end |=> (pause_lat_reg ? seg_reg == sftx_pkg::SEG_PAUSE && sent_oe : frame_done && !frame_busy))
    else $error("pause handling after checksum wrong");

  AST_REQUEST_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL4]
    $rose(req_pend_reg) |-> $past(trig_req || addr_req || poll_req))
    else $error("frame sent without request");

  AST_ANGLE_DATA: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL1]
    start && mode == sftx_pkg::MODE_FREE |=> data_nib_reg == $past(angle_in[15:4]))
    else $error("data nibbles do not hold angle code");

  AST_TICK_PERIOD: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL9]
    tick && !prog_mode && !seg_end |=> presc_reg == 8'h00 ##1
      (presc_reg == 8'h01 || div_lat_reg == 8'h00 || !$past(ce) || $past(prog_mode)))
    else $error("tick prescaler misaligned");

endmodule : sftx_top

// ===== verif/sftx_rx_model.sv
// receiver model: decodes frames from the open-drain line
// assumes line pulled up, low while sent_oe is high
`timescale 1ns/1ps
package sftx_rxv_pkg;
  function automatic logic [3:0] crc4(input logic [11:0] d);
    logic [7:0] r;
    logic [3:0] c;
    c = 4'h5;
    for (int i = 0; i < 4; i++)
    begin
      r = {c, 4'h0};
      for (int b = 7; b >= 4; b--)
        if (r[b])
          r = r ^ 8'(9'h1d << (b - 4));
      c = r[3:0] ^ ((i < 3) ? d[11 - 4 * i -: 4] : 4'h0);
    end
    return c;
  endfunction : crc4
endpackage : sftx_rxv_pkg

module sftx_rx_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // line and frame end
  input  wire logic        sent_oe,
  input  wire logic        frame_done,
  // decoded frame
  output logic             rx_valid,
  output logic      [3:0]  rx_stat,
  output logic      [11:0] rx_data,
  output logic             rx_crc_ok,
  output logic             rx_low_ok
);
  int         len;
  int         lowc;
  int         tclk;
  int         seg;
  bit         act;
  bit         lok;
  bit         oe_d;
  logic [3:0] nib [1:5];

  task automatic close_seg();
    if (seg == 0)
      tclk = (len + 28) / 56;
    else if (seg <= 5)
      nib[seg] = 4'((len + tclk / 2) / tclk - 12);
    if (seg <= 5 && lowc != 5 * tclk)
      lok = 0;
    if (seg == 5)
    begin
      rx_valid  <= 1'b1;
      rx_stat   <= nib[1];
      rx_data   <= {nib[2], nib[3], nib[4]};
      rx_crc_ok <= (sftx_rxv_pkg::crc4({nib[2], nib[3], nib[4]}) == nib[5]);
      rx_low_ok <= lok;
    end
  endtask : close_seg

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act = 0;
      oe_d = 0;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (sent_oe && !oe_d)
      begin
        if (act)
          close_seg();
        seg = act ? seg + 1 : 0;
        if (!act)
          lok = 1;
        act = 1;
        len = 0;
        lowc = 0;
      end
      else if (frame_done && act)
      begin
        close_seg();
        act = 0;
      end
      else if (act && !sent_oe && seg >= 1 && seg <= 5 && len > 40 * tclk)
        act = 0;
      len++;
      lowc += sent_oe;
      oe_d = sent_oe;
    end
  end
endmodule : sftx_rx_model

// ===== verif/tb_sftx_top.sv
// testbench of the frame transmitter with queued expectations
// assumes sftx_pkg, sftx_top and the receiver model
`timescale 1ns/1ps
module tb_sftx_top;
  logic        ref_clk, rst_n, ce, reg_we, reg_re, prog_mode, trig_req, addr_req, poll_req, re_d;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] angle_in, ang;
  logic [3:0]  status_in, rx_stat, st;
  logic [1:0]  addr_sel, sent_drive;
  logic        sent_out, sent_oe, frame_busy, frame_done, rx_valid, rx_crc_ok, rx_low_ok;
  logic [11:0] rx_data;
  logic [31:0] rd_q[$], mk_q[$], fr_q[$], len_q[$], lv, d;
  int          mismatches, checked, nframes, blen, tclk, n0, pz;
  logic [7:0]  ra[7];
  logic [31:0] re[7];

  sftx_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .angle_in(angle_in), .status_in(status_in),
    .prog_mode(prog_mode), .trig_req(trig_req), .addr_req(addr_req), .addr_sel(addr_sel), .poll_req(poll_req),
    .sent_out(sent_out), .sent_oe(sent_oe), .sent_drive(sent_drive), .frame_busy(frame_busy),
    .frame_done(frame_done));
  sftx_rx_model RX (.ref_clk(ref_clk), .rst_n(rst_n), .sent_oe(sent_oe), .frame_done(frame_done),
    .rx_valid(rx_valid), .rx_stat(rx_stat), .rx_data(rx_data), .rx_crc_ok(rx_crc_ok), .rx_low_ok(rx_low_ok));

  initial
  begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic finish_test();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_we <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_we <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge ref_clk);
    reg_re <= 1;
    reg_addr <= a;
    rd_q.push_back(e);
    mk_q.push_back(m);
    @(posedge ref_clk);
    reg_re <= 0;
  endtask : rd

  task automatic req(input int k, input logic [1:0] sel);
    @(posedge ref_clk);
    trig_req <= (k == 0);
    addr_req <= (k == 1);
    poll_req <= (k == 2);
    addr_sel <= sel;
    @(posedge ref_clk);
    trig_req <= 0;
    addr_req <= 0;
    poll_req <= 0;
  endtask : req

  task automatic expect_frame(input logic [15:0] a, input logic [3:0] s, input int p);
    logic [11:0] v;
    v = a[15:4];
    fr_q.push_back({16'h0, s, v});
    len_q.push_back({16'(tclk), 16'(116 + s + v[11:8] + v[7:4] + v[3:0] + sftx_rxv_pkg::crc4(v) + p)});
  endtask : expect_frame

  task automatic wait_done();
    int n;
    n = 0;
    while (frame_done !== 1'b1 && n < 20000)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20000)
    begin
      mismatches++;
      $display("BAD %0t frame wait timed out", $time);
      finish_test();
    end
    @(posedge ref_clk);
  endtask : wait_done

  always @(posedge ref_clk)
  begin
    re_d <= reg_re;
    if (re_d === 1'b1)
      cmp(reg_rdata & mk_q.pop_front(), rd_q.pop_front(), "rdata");
    else if (re_d === 1'b0)
      cmp(reg_rdata, 32'h0, "rdata idle");
    if (rx_valid === 1'b1 && fr_q.size() == 0)
      cmp(0, 1, "extra frame");
    else if (rx_valid === 1'b1)
    begin
      cmp({16'h0, rx_stat, rx_data}, fr_q.pop_front(), "frame");
      cmp({rx_crc_ok, rx_low_ok}, 2'b11, "crc low");
    end
    if (frame_busy === 1'b1)
      blen++;
    if (frame_done === 1'b1)
      nframes++;
    if (frame_done === 1'b1 && len_q.size() > 0)
    begin
      lv = len_q.pop_front();
      cmp((blen + lv[31:16] / 2) / lv[31:16], lv[15:0], "ticks");
    end
    if (prog_mode === 1'b1 || frame_done === 1'b1)
      blen = 0;
  end

  initial
  begin
    void'($urandom(80));
    {rst_n, reg_we, reg_re, prog_mode, trig_req, addr_req, poll_req, addr_sel, reg_addr, reg_wdata} = '0;
    ce = 1;
    angle_in = 16'($urandom);
    status_in = 4'($urandom);
    tclk = 60;
    ra = '{sftx_pkg::ADDR_CTRL, sftx_pkg::ADDR_TICK, sftx_pkg::ADDR_DRIVE, sftx_pkg::ADDR_PAUSE,
           sftx_pkg::ADDR_UNIT, sftx_pkg::ADDR_SERIAL, 8'h1c};
    re = '{32'(sftx_pkg::CTRL_RST), 32'(sftx_pkg::TICK_DIV_RST), 32'(sftx_pkg::DRIVE_RST),
           32'(sftx_pkg::PAUSE_RST), 32'(sftx_pkg::UNIT_RST), 32'(sftx_pkg::SERIAL_RST), 32'h0};
    repeat (16) @(posedge ref_clk);
    rst_n <= 1;
    expect_frame(angle_in, status_in, 0);
    for (int i = 0; i < 7; i++)
      rd(ra[i], re[i], 32'hffffffff);
    wr(sftx_pkg::ADDR_STATUS, 32'hffffffff);
    rd(sftx_pkg::ADDR_STATUS, {angle_in[15:4], 4'h1}, 32'hffff);
    wr(sftx_pkg::ADDR_CTRL, 32'h3);
    wr(sftx_pkg::ADDR_TICK, 32'h3);
    tclk = 4;
    d = $urandom;
    wr(sftx_pkg::ADDR_DRIVE, d);
    @(posedge ref_clk);
    cmp(sent_drive, d[1:0], "drive");
    wait_done();
    repeat (300) @(posedge ref_clk);
    cmp(nframes, 1, "untriggered");
    ce <= 0;
    wr(sftx_pkg::ADDR_DRIVE, ~d);
    ce <= 1;
    @(posedge ref_clk);
    cmp(sent_drive, d[1:0], "ce hold");
    for (int i = 0; i < 4; i++)
    begin
      pz = (i == 1) ? 3 : 12 + $urandom_range(40);
      wr(sftx_pkg::ADDR_PAUSE, pz);
      wr(sftx_pkg::ADDR_CTRL, (i == 0 || i == 3) ? 32'h3 : 32'hb);
      pz = (i == 0 || i == 3) ? 0 : (pz < 12) ? 12 : pz;
      ang = (i == 0) ? 16'h0 : (i == 3) ? 16'hffff : 16'($urandom);
      st = 4'($urandom);
      @(posedge ref_clk);
      angle_in <= ang;
      status_in <= st;
      expect_frame(ang, st, pz);
      req(0, 2'h0);
      wait_done();
    end
    n0 = nframes;
    wr(sftx_pkg::ADDR_UNIT, 32'h2);
    wr(sftx_pkg::ADDR_CTRL, 32'h5);
    for (int s = 0; s < 4; s++)
    begin
      if (s == 2)
        expect_frame(angle_in, status_in, 0);
      req(1, 2'(s));
      if (s == 2)
        wait_done();
      else
        repeat (30) @(posedge ref_clk);
    end
    cmp(nframes, n0 + 1, "addressed count");
    wr(sftx_pkg::ADDR_UNIT, 32'h9);
    wr(sftx_pkg::ADDR_CTRL, 32'h7);
    for (int k = 0; k < 6; k++)
    begin
      if (k % 3 == 1)
        expect_frame(angle_in, status_in, 0);
      req(2, 2'h0);
      if (k % 3 == 1)
        wait_done();
      else
        repeat (30) @(posedge ref_clk);
    end
    cmp(nframes, n0 + 3, "polled count");
    wr(sftx_pkg::ADDR_SERIAL, d);
    wr(sftx_pkg::ADDR_CTRL, 32'h13);
    for (int k = 0; k < 2; k++)
    begin
      expect_frame(angle_in, {d[15 - k], k == 0, status_in[1:0]}, 0);
      req(0, 2'h0);
      wait_done();
    end
    n0 = nframes;
    wr(sftx_pkg::ADDR_CTRL, 32'h3);
    req(0, 2'h0);
    repeat (400) @(posedge ref_clk);
    prog_mode <= 1;
    repeat (2) @(posedge ref_clk);
    cmp({sent_oe, frame_busy, sent_out}, 3'b000, "abort");
    rd(sftx_pkg::ADDR_STATUS, {angle_in[15:4], 4'h2}, 32'hffff);
    prog_mode <= 0;
    repeat (300) @(posedge ref_clk);
    cmp(nframes, n0, "lost frame");
    expect_frame(angle_in, status_in, 0);
    req(0, 2'h0);
    wait_done();
    repeat (10) @(posedge ref_clk);
    finish_test();
  end
endmodule : tb_sftx_top
